// ---- rtl/adcc_pkg.sv ----
// Purpose: shared constants and types of the converter control block
// Assumes: 20 MHz pclk, registers one per aligned 32-bit APB word
// Notes:   register byte address is four times the register index
package adcc_pkg;

  // clock and conversion timing
  localparam int CLK_NS       = 50;
  localparam int RC_TAD_NS    = 4000;            // typical rc bit period
  localparam int RC_HALF_CYC  = (RC_TAD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int HALF_2TOSC   = 1;               // half of 2 tosc
  localparam int HALF_8TOSC   = 4;
  localparam int HALF_32TOSC  = 16;
  localparam int CONV_HALVES  = 19;              // 9.5 bit periods
  localparam int NUM_CHAN     = 5;
  localparam int NUM_PINS     = 6;
  localparam int ADDR_W       = 12;

  // register indices and byte addresses
  localparam logic [7:0] IDX_PORT  = 8'h05;
  localparam logic [7:0] IDX_INTC  = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS_ONE  = 8'h0C;
  localparam logic [7:0] IDX_RES   = 8'h1E;
  localparam logic [7:0] IDX_CTL0  = 8'h1F;
  localparam logic [7:0] IDX_TRIS  = 8'h85;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES_ONE  = 8'h8C;
  localparam logic [7:0] IDX_CFG1  = 8'h9F;
  localparam logic [ADDR_W-1:0] A_PORT = {2'h0, IDX_PORT, 2'h0};
  localparam logic [ADDR_W-1:0] A_INTC = {2'h0, IDX_INTC, 2'h0};
  localparam logic [ADDR_W-1:0] A_PERIPHERAL_IRQ_FLAGS_ONE = {2'h0, IDX_PERIPHERAL_IRQ_FLAGS_ONE, 2'h0};
  localparam logic [ADDR_W-1:0] A_RES  = {2'h0, IDX_RES, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTL0 = {2'h0, IDX_CTL0, 2'h0};
  localparam logic [ADDR_W-1:0] A_TRIS = {2'h0, IDX_TRIS, 2'h0};
  localparam logic [ADDR_W-1:0] A_PERIPHERAL_IRQ_ENABLES_ONE = {2'h0, IDX_PERIPHERAL_IRQ_ENABLES_ONE, 2'h0};
  localparam logic [ADDR_W-1:0] A_CFG1 = {2'h0, IDX_CFG1, 2'h0};

  // field positions
  localparam int B_ON    = 0;                    // converter_enable
  localparam int B_GO    = 2;                    // start / busy
  localparam int B_CHS   = 3;                    // channel_select lsb
  localparam int B_CKS   = 6;                    // conv_clock_select lsb
  localparam int B_DONE  = 6;                    // conversion_done_flag
  localparam int B_DIE   = 6;                    // conversion_done_irq_enable
  localparam int B_GIE   = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE  = 6;

  // implemented bits and reset values
  localparam logic [7:0] M_CTL0   = 8'hFD;
  localparam logic [7:0] M_CFG1   = 8'h07;
  localparam logic [7:0] M_PINS   = 8'h3F;
  localparam logic [7:0] R_CTL0   = 8'h00;
  localparam logic [7:0] R_INTC   = 8'h00;
  localparam logic [2:0] R_CFG1   = 3'h0;
  localparam logic [5:0] R_TRIS   = 6'h3F;
  localparam logic [5:0] R_LATCH  = 6'h00;
  localparam logic [3:0] CCP_SPECIAL = 4'hB;

  // clock-select codes
  localparam logic [1:0] CKS_2  = 2'h0;
  localparam logic [1:0] CKS_8  = 2'h1;
  localparam logic [1:0] CKS_32 = 2'h2;

  typedef logic [NUM_CHAN-1:0][7:0] adcc_ain_t;

  // channel to port pin: an0..an3 on pins 0..3, an4 on pin 5
  function automatic logic [2:0] adcc_chan_pin(input logic [2:0] ch);
    adcc_chan_pin = (ch == 3'h4) ? 3'h5 : ch;
  endfunction

  // pin_config_field to analog pin mask
  function automatic logic [5:0] adcc_analog_mask(input logic [2:0] cfg);
    unique case (cfg)
      3'h0:    adcc_analog_mask = 6'h2F;
      3'h1:    adcc_analog_mask = 6'h0F;
      3'h2:    adcc_analog_mask = 6'h07;
      3'h3:    adcc_analog_mask = 6'h03;
      3'h4:    adcc_analog_mask = 6'h01;
      default: adcc_analog_mask = 6'h00;
    endcase
  endfunction

  typedef enum logic {SAR_IDLE, SAR_CONV} adcc_sar_st_t;

  typedef struct packed {
    adcc_sar_st_t st;
    logic [5:0]   div;
    logic [4:0]   halves;
    logic [7:0]   sample;
    logic [7:0]   acc;
    logic [7:0]   trial;
    logic         done;
  } adcc_sar_t;

  typedef struct packed {
    logic [7:0]          ctl0;
    logic [2:0]          cfg1;
    logic [5:0]          tris;
    logic [5:0]          latch;
    logic [7:0]          intc;
    logic                conversion_done_flag;
    logic                conversion_done_irq_enable;
    logic [NUM_PINS-1:0] p1;
    logic [NUM_PINS-1:0] p2;
    adcc_ain_t           a1;
    adcc_ain_t           a2;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                start;
    logic                tmr_clr;
    logic                irq;
  } adcc_top_t;

endpackage

// ---- rtl/adcc_sar.sv ----
// Purpose: bit-period timing and successive approximation of one sample
// Assumes: start is a one-cycle pulse; sample is stable at start
// Notes:   abort drops a conversion at once without a done pulse
`timescale 1ns/100ps
module adcc_sar (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [1:0] clk_sel,
  input  wire logic [7:0] sample,
  // result
  output logic            busy,
  output logic            done,
  output logic [7:0]      result
);
  import adcc_pkg::*;

  adcc_sar_t q, d;
  logic [5:0] half_len;

  // half bit period in pclk cycles per clock-select code
  always_comb begin
    unique case (clk_sel)
      CKS_2:   half_len = 6'(HALF_2TOSC);
      CKS_8:   half_len = 6'(HALF_8TOSC);
      CKS_32:  half_len = 6'(HALF_32TOSC);
      default: half_len = 6'(RC_HALF_CYC);
    endcase
  end

  // sample is held from start, like the disconnected hold capacitor
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      SAR_IDLE: begin
        if (start && !abort) begin
          d.st     = SAR_CONV;
          d.div    = 6'h00;
          d.halves = 5'h00;
          d.sample = sample;
          d.acc    = 8'h00;
          d.trial  = 8'h80;
        end
      end
      SAR_CONV: begin
        if (abort) begin
          d.st = SAR_IDLE;
        end else if (q.div == half_len - 6'h01) begin
          d.div    = 6'h00;
          d.halves = q.halves + 5'h01;
          // one bit decided at the end of the first half of each of the first eight periods
          if (!q.halves[0] && q.trial != 8'h00) begin
            if (q.sample >= (q.acc | q.trial)) begin
              d.acc = q.acc | q.trial;
            end
            d.trial = q.trial >> 1;
          end
          if (q.halves == 5'(CONV_HALVES - 1)) begin
            d.st   = SAR_IDLE;
            d.done = 1'b1;
          end
        end else begin
          d.div = q.div + 6'h01;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy   = (q.st == SAR_CONV);
  assign done   = q.done;
  assign result = q.acc;

endmodule // adcc_sar

// ---- rtl/adcc_top.sv ----
// Purpose: converter control, port pins, trigger and apb register file
// Assumes: trigger and mode come from on-chip logic on pclk
// Notes:   pins and analog levels pass two flops before use
`timescale 1ns/100ps
// Summary of operation
// - conversion runs whatever channel select and direction bits hold
// - port reads return zero on pins configured analog
// - a digitally configured selected pin is still converted
// - clock select: 2, 8, 32 oscillator periods or internal rc
// - rc bit period lies within 2 to 6 us, typically 4 us
// - mode 1011 trigger with converter on sets start and converts
// - every special trigger clears the sixteen-bit timer
// - trigger ignored when converter off, timer still cleared
// - result unknown after power-on, kept through other resets
// - unimplemented bits read zero and ignore writes
// - finish loads result, clears start bit, sets done flag
// - a conversion lasts nine and a half bit periods
// - reset turns converter off and aborts conversion
module adcc_top (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [adcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // port pins
  input  wire logic [adcc_pkg::NUM_PINS-1:0] pin_in,
  output logic [adcc_pkg::NUM_PINS-1:0] pin_out,
  output logic [adcc_pkg::NUM_PINS-1:0] pin_oe_n,
  input  wire adcc_pkg::adcc_ain_t      ain_level,
  // capture/compare unit
  input  wire logic                     ccp_trigger,
  input  wire logic [3:0]               capcomp_mode_field,
  output logic                          timer_clear,
  // interrupt request towards the processor
  output logic                          irq
);
  import adcc_pkg::*;

  adcc_top_t  q, d;
  logic [7:0] res_q;
  logic       sar_done;
  logic [7:0] sar_res;
  logic [7:0] sel_level;
  logic [7:0] rd_data;
  logic       hit;
  logic       wr;
  logic       go_req;
  logic [2:0] sel_ch;
  logic [2:0] sel_pin;
  logic [5:0] amask;

  assign sel_ch  = q.ctl0[B_CHS +: 3];
  assign sel_pin = adcc_chan_pin(sel_ch);
  assign amask   = adcc_analog_mask(q.cfg1);

  // level handed to the converter; direction bits only pick the source
  always_comb begin
    if (sel_ch >= 3'(NUM_CHAN)) begin
      sel_level = 8'h00;                                    // no such input
    end else if (!q.tris[sel_pin]) begin
      sel_level = q.latch[sel_pin] ? 8'hFF : 8'h00;
    end else begin
      sel_level = q.a2[sel_ch];
    end
  end

  // read mux; unimplemented bits come back as zero
  always_comb begin
    hit     = 1'b1;
    rd_data = 8'h00;
    unique case (paddr)
      A_PORT:  rd_data = {2'h0, q.p2 & ~amask};
      A_INTC:  rd_data = q.intc;
      A_PERIPHERAL_IRQ_FLAGS_ONE:  rd_data = 8'(q.conversion_done_flag) << B_DONE;
      A_RES:   rd_data = res_q;
      A_CTL0:  rd_data = q.ctl0 & M_CTL0;
      A_TRIS:  rd_data = {2'h0, q.tris};
      A_PERIPHERAL_IRQ_ENABLES_ONE:  rd_data = 8'(q.conversion_done_irq_enable) << B_DIE;
      A_CFG1:  rd_data = {5'h00, q.cfg1};
      default: hit     = 1'b0;
    endcase
  end

  assign wr     = psel && penable && pwrite && q.pready;
  assign go_req = wr && (paddr == A_CTL0) && pwdata[B_GO];

  // next state of registers, bus answer and converter control
  always_comb begin
    d         = q;
    d.start   = 1'b0;
    d.tmr_clr = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    // two-flop synchronisers for pins and analog levels
    d.p1 = pin_in;
    d.p2 = q.p1;
    d.a1 = ain_level;
    d.a2 = q.a1;
    // answer one cycle into the access phase
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !hit;
      d.prdata  = {24'h000000, rd_data};
    end
    // register writes; masks keep unimplemented bits at zero
    if (wr) begin
      unique case (paddr)
        A_PORT: d.latch = pwdata[5:0] & M_PINS[5:0];
        A_INTC: d.intc  = pwdata[7:0];
        A_PERIPHERAL_IRQ_FLAGS_ONE: d.conversion_done_flag  = pwdata[B_DONE];
        A_CTL0: begin
          d.ctl0 = pwdata[7:0] & M_CTL0;
          d.ctl0[B_GO] = q.ctl0[B_GO];                      // busy is hardware's
        end
        A_TRIS: d.tris = pwdata[5:0];
        A_PERIPHERAL_IRQ_ENABLES_ONE: d.conversion_done_irq_enable = pwdata[B_DIE];
        A_CFG1: d.cfg1 = pwdata[2:0] & M_CFG1[2:0];
        default: ;
      endcase
    end
    // software start; channel and direction do not gate it
    if (go_req && d.ctl0[B_ON] && !q.ctl0[B_GO]) begin
      d.ctl0[B_GO] = 1'b1;
      d.start      = 1'b1;
    end
    // special event trigger always clears the timer
    if (ccp_trigger && capcomp_mode_field == CCP_SPECIAL) begin
      d.tmr_clr = 1'b1;
      if (q.ctl0[B_ON] && !q.ctl0[B_GO]) begin
        d.ctl0[B_GO] = 1'b1;
        d.start      = 1'b1;
      end
    end
    // completion; set wins over a software clear in the same cycle
    if (sar_done) begin
      d.ctl0[B_GO] = 1'b0;
      d.conversion_done_flag       = 1'b1;
    end
    // converter off cancels any start or conversion in flight
    if (!d.ctl0[B_ON]) begin
      d.ctl0[B_GO] = 1'b0;
      d.start      = 1'b0;
    end
    d.irq = d.conversion_done_flag && d.conversion_done_irq_enable && d.intc[B_PERIPHERAL_IRQ_ENABLE] && d.intc[B_GIE];
  end

  // control state; device reset leaves the converter off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.ctl0  <= R_CTL0;
      q.cfg1  <= R_CFG1;
      q.tris  <= R_TRIS;
      q.latch <= R_LATCH;
      q.intc  <= R_INTC;
    end else begin
      q <= d;
    end
  end

  // result has no reset, so it survives every reset but power-up
  always_ff @(posedge pclk) begin
    if (sar_done) begin
      res_q <= sar_res;
    end
  end

  // approximation engine; abort while converter is off
  adcc_sar u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (q.start),
    .abort   (!q.ctl0[B_ON]),
    .clk_sel (q.ctl0[B_CKS +: 2]),
    .sample  (sel_level),
    .busy    (),                                            // go bit tracks it
    .done    (sar_done),
    .result  (sar_res)
  );

  // outputs straight from flops
  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign pin_out     = q.latch;
  assign pin_oe_n    = q.tris;                              // low = driving
  assign timer_clear = q.tmr_clr;
  assign irq         = q.irq;

endmodule // adcc_top

// ---- verif/adcc_asserts.sv ----
// Purpose: port-level temporal checks of adcc_top
// Assumes: single pclk domain, presetn asynchronous active low
// Notes:   bound to every adcc_top instance
`timescale 1ns/100ps
module adcc_asserts (
  // clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // apb
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // pins, trigger, interrupt
  input wire logic [adcc_pkg::NUM_PINS-1:0] pin_oe_n,
  input wire logic                          ccp_trigger,
  input wire logic [3:0]                    capcomp_mode_field,
  input wire logic                          timer_clear,
  input wire logic                          irq
);
  import adcc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a completed write, the only legal cause of a direction change or an irq drop
  wire wr = psel & penable & pready & pwrite;
  wire trg = ccp_trigger & (capcomp_mode_field == CCP_SPECIAL);

  property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("slverr without ready");
  property p_wait; psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  property p_tclr; trg |=> timer_clear ##1 !timer_clear; endproperty
  a_tclr: assert property (p_tclr) else $error("timer clear missed");
  property p_tcause; timer_clear |-> $past(trg); endproperty
  a_tcause: assert property (p_tcause) else $error("stray timer clear");
  // reset seen at two edges, so the async clear has surely landed
  logic rst_held;
  always_ff @(posedge pclk) rst_held <= !presetn;
  // reset values show while reset is held, so no disable here
  property p_rst;
    disable iff (1'b0)
    !presetn && rst_held |-> pin_oe_n == 6'h3F && !irq && !timer_clear
      && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_dir; !$stable(pin_oe_n) |-> $past(wr); endproperty
  a_dir: assert property (p_dir) else $error("direction moved alone");
  property p_irqf; $fell(irq) |-> $past(wr) || $past(wr, 2); endproperty
  a_irqf: assert property (p_irqf) else $error("irq dropped alone");

  // main scenarios
  c_trig: cover property (trg);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule // adcc_asserts

bind adcc_top adcc_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .pin_oe_n, .ccp_trigger,
  .capcomp_mode_field, .timer_clear, .irq);

// ---- verif/adcc_far.sv ----
// Purpose: board pins and capture/compare trigger around adcc_top
// Assumes: board levels and fire requests come from the bench
// Notes:   trigger is registered, so it lands one cycle after fire
`timescale 1ns/100ps
module adcc_far (
  // clock
  input wire logic                          pclk,
  // pin drive from block and board
  input wire logic [adcc_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [adcc_pkg::NUM_PINS-1:0] pin_oe_n,
  input wire logic [adcc_pkg::NUM_PINS-1:0] board_level,
  // trigger request
  input wire logic                          fire,
  output logic [adcc_pkg::NUM_PINS-1:0]     pin_in,
  output logic                              ccp_trigger
);
  import adcc_pkg::*;
  // driven pins show the latch, released pins the board level
  assign pin_in = (pin_out & ~pin_oe_n) | (board_level & pin_oe_n);
  // one-cycle special event pulse per request
  always_ff @(posedge pclk) ccp_trigger <= fire;
endmodule // adcc_far

// ---- verif/tb_adcc_top.sv ----
// Purpose: self-checking bench of adcc_top
// Assumes: 20 MHz pclk, apb slave with one wait state
// Notes:   expectations come from bench tables, except the dut result kept over reset
`timescale 1ns/100ps
module tb_adcc_top;
  import adcc_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, fire, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, r, res;
  logic              pready, pslverr, ccp_trigger, timer_clear, irq;
  logic [5:0]        pin_in, pin_out, pin_oe_n, board;
  logic [3:0]        capcomp_mode_field;
  adcc_ain_t         ain_level;
  logic [31:0]       seed = 32'h000089F1;
  int                bad_count, cmp_count, tc_count, now, st, cyc, ch;
  localparam logic [ADDR_W-1:0] RA [5] = '{A_CTL0, A_CFG1, A_TRIS,
                                           A_PERIPHERAL_IRQ_FLAGS_ONE, A_PERIPHERAL_IRQ_ENABLES_ONE};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
  localparam logic [7:0] WD [5] = '{8'h02, 8'hFF, 8'hFF, 8'hBF, 8'hFF};
  localparam logic [7:0] WE [5] = '{8'h00, 8'h07, 8'h3F, 8'h00, 8'h40};
  localparam logic [7:0] IV [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

  adcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
    .ain_level, .ccp_trigger, .capcomp_mode_field, .timer_clear, .irq);
  adcc_far u_far (.pclk, .pin_out, .pin_oe_n, .board_level(board),
    .fire, .pin_in, .ccp_trigger);

  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // cycle count and timer clear pulses
  always @(posedge pclk) begin
    now <= now + 1;
    if (timer_clear === 1'b1) tc_count <= tc_count + 1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // analog pin mask per pin config code
  function automatic logic [5:0] amask(input int c);
    logic [5:0] t [8] = '{6'h2F, 6'h0F, 6'h07, 6'h03, 6'h01, 0, 0, 0};
    return t[c];
  endfunction

  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; idle cycle first keeps drivers single per step
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(A_CTL0);
      n++;
    end while (r[B_GO] !== 1'b0 && n < 500);
    if (r[B_GO] !== 1'b0) bad_count++;
    cyc = now - st;
  endtask
  // enable first, start in a later write
  task automatic conv(input int ck, input int c);
    wr(A_CTL0, {ck[1:0], c[2:0], 3'b001});
    wr(A_CTL0, {ck[1:0], c[2:0], 3'b101});
    st = now;
    wait_done();
  endtask
  // rc window is wide, the divided clocks exact plus poll slack
  task automatic chk_time(input int ck);
    int lo, hi;
    lo = (ck == 3) ? 380 : 19 * (1 << (2 * ck));
    hi = (ck == 3) ? 1148 : lo + 8;
    chk("conv time", 1, cyc >= lo && cyc <= hi);
  endtask
  task automatic chk_res(input logic [7:0] e);
    rd(A_RES);
    chk("result", e, r);
    rd(A_PERIPHERAL_IRQ_FLAGS_ONE);
    chk("done flag", 32'h40, r);
    wr(A_PERIPHERAL_IRQ_FLAGS_ONE, 8'h00);
  endtask
  task automatic pulse();
    @(posedge pclk) fire <= 1'b1;
    @(posedge pclk) fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    close_out();
  end

  initial begin
    {presetn, psel, penable, pwrite, fire} = '0;
    paddr = '0;
    pwdata = '0;
    board = '0;
    ain_level = '0;
    capcomp_mode_field = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then writes to unimplemented bits
    foreach (RA[i]) begin
      rd(RA[i]);
      chk("reset value", RV[i], r);
      wr(RA[i], WD[i]);
      rd(RA[i]);
      chk("masked write", WE[i], r);
    end
    rd(12'h004);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, r);
    // analog pins read low on the port
    board <= 6'(rnd());
    for (int c = 0; c < 8; c++) begin
      wr(A_CFG1, 8'(c));
      rd(A_PORT);
      chk("port read", board & ~amask(c), r);
    end
    // random conversions over every clock select and random pin configs;
    // every code checked for result as well as timing, the ideal model loses no accuracy
    for (int k = 0; k < 8; k++) begin
      ain_level <= adcc_ain_t'({rnd(), rnd()});
      ch = rnd() % 5;
      wr(A_CFG1, 8'(rnd() % 8));
      conv(k % 4, ch);
      chk_time(k % 4);
      chk_res(ain_level[ch]);
    end
    // a driven pin converts its own output level
    wr(A_TRIS, 8'h3E);
    wr(A_CFG1, 8'h07);
    for (int l = 0; l < 2; l++) begin
      wr(A_PORT, 8'(l));
      rd(A_PORT);
      chk("driven pin", {board[5:1], l[0]}, r);
      conv(2, 0);
      chk_res({8{l[0]}});
    end
    wr(A_TRIS, 8'h3F);
    // a channel code with no input still converts and finishes
    conv(2, 5);
    chk_res(8'h00);
    // triggers while off and in a foreign mode
    capcomp_mode_field <= CCP_SPECIAL;
    wr(A_CTL0, 8'h00);
    pulse();
    rd(A_CTL0);
    chk("off trigger busy", 0, r);
    capcomp_mode_field <= 4'hA;
    pulse();
    capcomp_mode_field <= CCP_SPECIAL;
    ain_level <= adcc_ain_t'({rnd(), rnd()});
    wr(A_CTL0, 8'h99);
    repeat (20) @(posedge pclk);
    pulse();
    rd(A_CTL0);
    chk("trigger busy", 32'h9D, r);
    wait_done();
    chk("timer clears", 2, tc_count);
    // irq only with all three enables
    foreach (IV[i]) begin
      wr(A_INTC, IV[i]);
      repeat (2) @(posedge pclk);
      chk("irq", IV[i] == 8'hC0, irq);
    end
    chk_res(ain_level[3]);
    // reset in mid-conversion
    res = r;
    rd(A_RES);
    res = r;
    wr(A_CTL0, 8'h81);
    wr(A_CTL0, 8'h85);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL0);
    chk("ctl0 after reset", 0, r);
    repeat (400) @(posedge pclk);
    rd(A_PERIPHERAL_IRQ_FLAGS_ONE);
    chk("flag after abort", 0, r);
    rd(A_RES);
    chk("result kept", res, r);
    close_out();
  end
endmodule // tb_adcc_top
